/* File: lfm_fault_manager.sv */
// Laser fault and alarm manager: monitor post-processing, fault and shutdown gate logic
//
// Notes on behaviour
// - Temperature signed, other channels unsigned codes
// - Each conversion compared against four thresholds
// - Five channels converted in round-robin unless short-cycled
// - Enabled active supply-low: temperature and supply only
// - External monitors right shifted zero to seven
// - Result registers hold shifted values
// - Fault output gated by its own masks
// - Unlatched fault follows alarm condition
// - Latched fault released by reset, disable, power
// - Gate-routed fault released only by disable, power
// - Alarms except bias-max ignored at start
// - Fault output: low supply 1, disable 0
// - Shutdown gate separately masked, always latches
// - Gate driven per polarity above power-on
// - Gate undriven below analog power-on level
// - Latched shutdown released by disable or power
// - Re-init clears alarms except supply-low
// - Bias and modulation enabled only when clear
// - Trap bits set for every alarm occurrence
// - Trap bits cleared by host zero writes
// - Two read-only identification bytes
// - Software disable acts as the pin
// - Supply-low forced at power-on, latches wait
`timescale 1ns/10ps
`default_nettype none

module lfm_fault_manager #(
  parameter logic [7:0] PART_ID = 8'h5a, // Arbitrary value
  parameter logic [7:0] REV_ID = 8'h01   // Arbitrary value
) (
  // Clock and reset
  input wire logic clock,
  input wire logic reset,
  // Supply and pins
  input wire logic belowPoa,
  input wire logic txDisable,
  output logic txFault,
  output logic gateOut,
  output logic gateOe,
  output logic biasEnable,
  output logic modEnable,
  // Converter
  input wire logic convDone,
  input wire logic [15:0] convRaw,
  output lfm_pkg::lfm_chan_t convChan,
  output logic [15:0] measResult [lfm_pkg::NUM_CHAN],
  output lfm_pkg::lfm_flags_t chanFlags [lfm_pkg::NUM_CHAN],
  // Quick-trip and bias loop
  input wire logic [lfm_pkg::NUM_QT-1:0] quickTrip,
  input wire logic biasUpdate,
  // Thresholds and controls
  input wire lfm_pkg::lfm_thresh_t thresh [lfm_pkg::NUM_CHAN],
  input wire lfm_pkg::lfm_ctrl_t ctrl,
  // Trap bytes
  input wire logic trapWrite,
  input wire logic [lfm_pkg::NUM_ALM-1:0] trapWrData,
  output logic [lfm_pkg::NUM_ALM-1:0] alarmTrap,
  // Register port
  input wire logic regWrite,
  input wire logic regRead,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWrData,
  output logic [7:0] regRdData
);

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [7:0] polarity_r;
  logic [7:0] shiftA_r;
  logic [7:0] shiftB_r;
  logic [7:0] rdData_r;
  lfm_pkg::lfm_chan_t chan_r;
  lfm_pkg::lfm_chan_t chan_nxt;
  logic [15:0] meas_r [lfm_pkg::NUM_CHAN];
  lfm_pkg::lfm_flags_t flags_r [lfm_pkg::NUM_CHAN];
  logic vccLowCleared_r;
  logic faultHeld_r;
  logic shutdown_r;
  logic [3:0] ignoreCnt_r;
  logic outOn_r;
  logic [lfm_pkg::NUM_ALM-1:0] trap_r;

  // ----------------------------------------------------------------
  // Channel index and shift
  // ----------------------------------------------------------------
  function automatic logic [2:0] chanIdx(input lfm_pkg::lfm_chan_t c);
    case (c)
      lfm_pkg::CH_TEMP: chanIdx = 3'h0;
      lfm_pkg::CH_VCC: chanIdx = 3'h1;
      lfm_pkg::CH_MON_ONE: chanIdx = 3'h2;
      lfm_pkg::CH_MON_TWO: chanIdx = 3'h3;
      default: chanIdx = 3'h4;
    endcase
  endfunction : chanIdx

  // Compare strictly, signed for the temperature channel
  function automatic logic above(input logic sgn, input logic [15:0] a, input logic [15:0] b);
    above = sgn ? ($signed(a) > $signed(b)) : (a > b);
  endfunction : above

  wire logic [2:0] curIdx = chanIdx(chan_r);
  wire logic isTemp = (chan_r == lfm_pkg::CH_TEMP);
  wire logic [2:0] shiftOne = shiftA_r[lfm_pkg::SHIFT_ONE_LSB +: lfm_pkg::SHIFT_W];
  wire logic [2:0] shiftTwo = shiftA_r[lfm_pkg::SHIFT_TWO_LSB +: lfm_pkg::SHIFT_W];
  wire logic [2:0] shiftThree = shiftB_r[lfm_pkg::SHIFT_THREE_LSB +: lfm_pkg::SHIFT_W];
  wire logic [2:0] shiftSel = (chan_r == lfm_pkg::CH_MON_ONE) ? shiftOne :
                              (chan_r == lfm_pkg::CH_MON_TWO) ? shiftTwo :
                              (chan_r == lfm_pkg::CH_MON_THREE) ? shiftThree : 3'h0;
  wire logic [15:0] shifted = convRaw >> shiftSel;

  // Comparison of the shifted result against the current thresholds
  wire lfm_pkg::lfm_thresh_t curTh = thresh[curIdx];
  wire lfm_pkg::lfm_flags_t newFlags = '{
    hiAlarm: above(isTemp, shifted, curTh.hiAlarm),
    loAlarm: above(isTemp, curTh.loAlarm, shifted),
    hiWarn: above(isTemp, shifted, curTh.hiWarn),
    loWarn: above(isTemp, curTh.loWarn, shifted)
  };

  // ----------------------------------------------------------------
  // Alarm vector and masks
  // ----------------------------------------------------------------
  logic [lfm_pkg::NUM_CHAN-1:0] adcAlarm;
  genvar g;
  generate
    for (g = 0; g < lfm_pkg::NUM_CHAN; g++) begin : gAdc
      assign adcAlarm[g] = flags_r[g].hiAlarm | flags_r[g].loAlarm;
    end
  endgenerate

  wire logic vccLow = flags_r[1].loAlarm;
  wire logic softOff = ctrl.softTxDisable;
  wire logic anyDisable = txDisable | softOff;
  wire logic ignoring = (ignoreCnt_r != '0);
  // Startup window hides all but the bias-max quick-trip
  wire logic [lfm_pkg::NUM_QT-1:0] qtKeep = {1'b1, {(lfm_pkg::NUM_QT-1){~ignoring}}};
  wire logic [lfm_pkg::NUM_ALM-2:0] rawAlarm = {quickTrip, adcAlarm};
  wire logic [lfm_pkg::NUM_ALM-2:0] effAlarm =
    {quickTrip & qtKeep, adcAlarm & {lfm_pkg::NUM_CHAN{~ignoring}}};
  wire logic faultLive =
    |(effAlarm & ctrl.faultMask[lfm_pkg::NUM_ALM-2:0]);
  wire logic gateRouted = shutdown_r & ctrl.faultMask[lfm_pkg::GATE_BIT];
  wire logic gateLive = |(effAlarm & ctrl.gateMask);
  wire logic vccLowEnabled = ctrl.faultMask[1] | ctrl.gateMask[1];
  wire logic shortCycle = vccLowEnabled & vccLow;

  // ----------------------------------------------------------------
  // Channel sequencing
  // ----------------------------------------------------------------
  always_comb begin
    case (chan_r)
      lfm_pkg::CH_TEMP: chan_nxt = lfm_pkg::CH_VCC;
      lfm_pkg::CH_VCC: chan_nxt = shortCycle ? lfm_pkg::CH_TEMP : lfm_pkg::CH_MON_ONE;
      lfm_pkg::CH_MON_ONE: chan_nxt = shortCycle ? lfm_pkg::CH_TEMP : lfm_pkg::CH_MON_TWO;
      lfm_pkg::CH_MON_TWO: chan_nxt = shortCycle ? lfm_pkg::CH_TEMP : lfm_pkg::CH_MON_THREE;
      default: chan_nxt = lfm_pkg::CH_TEMP;
    endcase
  end

  // Advance one channel per completed conversion
  always_ff @(posedge clock) begin
    if (reset) begin
      chan_r <= lfm_pkg::CH_TEMP;
    end else if (convDone) begin
      chan_r <= chan_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Output enable state and re-initialisation
  // ----------------------------------------------------------------
  wire logic outAllowed = ~belowPoa & ~anyDisable & ~shutdown_r & ~gateLive & ~vccLow;
  wire logic reinit = outAllowed & ~outOn_r;

  // Results, flags and supply-low handling
  always_ff @(posedge clock) begin
    if (reset) begin
      for (int i = 0; i < lfm_pkg::NUM_CHAN; i++) begin
        meas_r[i] <= 16'h0000;
        flags_r[i] <= '0;
      end
      vccLowCleared_r <= 1'b0;
    end else begin
      if (reinit) begin
        for (int i = 0; i < lfm_pkg::NUM_CHAN; i++) begin
          flags_r[i] <= '{hiAlarm: 1'b0, loAlarm: (i == 1) ? flags_r[i].loAlarm : 1'b0,
                          hiWarn: 1'b0, loWarn: 1'b0};
        end
      end
      if (convDone) begin
        meas_r[curIdx] <= shifted;
        flags_r[curIdx] <= newFlags;
        if (chan_r == lfm_pkg::CH_VCC) begin
          vccLowCleared_r <= ~newFlags.loAlarm;
        end
      end
      if (belowPoa) begin
        flags_r[1].loAlarm <= 1'b1;
        vccLowCleared_r <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Fault latch, shutdown latch and startup window
  // ----------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (reset) begin
      faultHeld_r <= 1'b0;
      shutdown_r <= 1'b0;
      outOn_r <= 1'b0;
      ignoreCnt_r <= 4'h0;
    end else begin
      if (anyDisable) begin
        faultHeld_r <= 1'b0;
      end else if (ctrl.faultLatchEn & faultLive & vccLowCleared_r) begin
        faultHeld_r <= 1'b1;
      end else if (ctrl.faultResetPulse) begin
        faultHeld_r <= 1'b0;
      end
      if (anyDisable) begin
        shutdown_r <= 1'b0;
      end else if (gateLive & vccLowCleared_r & ~belowPoa) begin
        shutdown_r <= 1'b1;
      end
      outOn_r <= outAllowed;
      if (reinit) begin
        ignoreCnt_r <= lfm_pkg::STARTUP_IGNORE;
      end else if (biasUpdate & ignoring) begin
        ignoreCnt_r <= ignoreCnt_r - 4'h1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Trap bytes
  // ----------------------------------------------------------------
  wire logic [lfm_pkg::NUM_ALM-1:0] trapSet = {shutdown_r, rawAlarm};
  wire logic [lfm_pkg::NUM_ALM-1:0] trapKeep = trapWrite ? (trap_r & trapWrData) : trap_r;

  // New alarms win over a host clear in the same cycle
  always_ff @(posedge clock) begin
    if (reset) begin
      trap_r <= lfm_pkg::TRAP_RST;
    end else begin
      trap_r <= trapKeep | trapSet;
    end
  end

  // ----------------------------------------------------------------
  // Register port
  // ----------------------------------------------------------------
  wire logic hitPol = (regAddr == lfm_pkg::ADDR_POLARITY);
  wire logic hitShA = (regAddr == lfm_pkg::ADDR_SHIFT_A);
  wire logic hitShB = (regAddr == lfm_pkg::ADDR_SHIFT_B);
  logic [7:0] rdMux;
  always_comb begin
    if (regAddr == lfm_pkg::ADDR_PART_ID) begin
      rdMux = PART_ID;
    end else if (regAddr == lfm_pkg::ADDR_REV_ID) begin
      rdMux = REV_ID;
    end else if (hitPol) begin
      rdMux = polarity_r;
    end else if (hitShA) begin
      rdMux = shiftA_r;
    end else if (hitShB) begin
      rdMux = shiftB_r;
    end else begin
      rdMux = lfm_pkg::UNMAPPED_READ;
    end
  end

  // Writable configuration and registered read data
  always_ff @(posedge clock) begin
    if (reset) begin
      polarity_r <= lfm_pkg::POLARITY_RST;
      shiftA_r <= lfm_pkg::SHIFT_RST;
      shiftB_r <= lfm_pkg::SHIFT_RST;
      rdData_r <= 8'h00;
    end else begin
      if (regWrite & hitPol) polarity_r <= regWrData;
      if (regWrite & hitShA) shiftA_r <= regWrData;
      if (regWrite & hitShB) shiftB_r <= regWrData;
      if (regRead) rdData_r <= rdMux;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  wire logic polBit = polarity_r[lfm_pkg::POL_BIT];
  assign txFault = belowPoa ? 1'b1 :
                   anyDisable ? 1'b0 :
                   (faultLive | faultHeld_r | gateRouted);
  assign gateOe = ~belowPoa;
  assign gateOut = shutdown_r ? polBit : ~polBit;
  assign biasEnable = outOn_r;
  assign modEnable = outOn_r;
  assign convChan = chan_r;
  assign measResult = meas_r;
  assign chanFlags = flags_r;
  assign alarmTrap = trap_r;
  assign regRdData = rdData_r;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_fault_below_poa: assert property (@(posedge clock) disable iff (reset)
    belowPoa |-> txFault) else $error("Fault output low below power-on level");
  a_fault_disable: assert property (@(posedge clock) disable iff (reset)
    (!belowPoa && txDisable) |-> !txFault) else $error("Fault output high while disabled");
  a_gate_hiz: assert property (@(posedge clock) disable iff (reset)
    belowPoa |-> !gateOe) else $error("Gate driven below power-on level");
  a_shutdown_holds: assert property (@(posedge clock) disable iff (reset)
    (shutdown_r && !anyDisable) |=> shutdown_r) else $error("Shutdown released early");
  a_outputs_off: assert property (@(posedge clock) disable iff (reset)
    (anyDisable || shutdown_r) |=> !biasEnable && !modEnable) else $error("Outputs on when off");
  a_short_cycle: assert property (@(posedge clock) disable iff (reset)
    (convDone && chan_r == lfm_pkg::CH_VCC && shortCycle) |=> chan_r == lfm_pkg::CH_TEMP)
    else $error("Sequence left short cycle");
  a_trap_sticky: assert property (@(posedge clock) disable iff (reset)
    (trap_r[0] && !trapWrite) |=> trap_r[0]) else $error("Trap bit lost");
  a_trap_sets: assert property (@(posedge clock) disable iff (reset)
    quickTrip[0] |=> trap_r[lfm_pkg::QT_LSB]) else $error("Trap bit not set");
  a_meas_shift: assert property (@(posedge clock) disable iff (reset)
    (convDone && chan_r == lfm_pkg::CH_MON_ONE) |=> meas_r[2] == $past(convRaw) >> $past(shiftOne))
    else $error("Result not shifted");
  a_ignore_window: assert property (@(posedge clock) disable iff (reset)
    reinit |=> ignoreCnt_r == lfm_pkg::STARTUP_IGNORE) else $error("Startup window not armed");
  a_fault_held: assert property (@(posedge clock) disable iff (reset)
    (faultHeld_r && !anyDisable && !ctrl.faultResetPulse) |=> faultHeld_r)
    else $error("Latched fault released early");
  a_vcc_forced: assert property (@(posedge clock) disable iff (reset)
    belowPoa |=> flags_r[1].loAlarm) else $error("Supply-low not forced below power-on");

endmodule : lfm_fault_manager

`default_nettype wire

/* File: lfm_pkg.sv */
// Constants, types and register map for the laser fault and alarm manager
package lfm_pkg;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_PART_ID = 8'h86;
  localparam logic [7:0] ADDR_REV_ID = 8'h87;
  localparam logic [7:0] ADDR_POLARITY = 8'h89;
  localparam logic [7:0] ADDR_SHIFT_A = 8'h8e;
  localparam logic [7:0] ADDR_SHIFT_B = 8'h8f;

  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int POL_BIT = 0;
  localparam int SHIFT_ONE_LSB = 0;
  localparam int SHIFT_TWO_LSB = 4;
  localparam int SHIFT_THREE_LSB = 0;
  localparam int SHIFT_W = 3;
  localparam logic [7:0] POLARITY_RST = 8'h00;
  localparam logic [7:0] SHIFT_RST = 8'h00;
  localparam logic [7:0] UNMAPPED_READ = 8'h00;

  // Alarm vector layout: converter alarms 0..4, quick-trips 5..8, gate 9
  localparam int NUM_CHAN = 5;
  localparam int NUM_QT = 4;
  localparam int NUM_ALM = 10;
  localparam int QT_LSB = 5;
  localparam int QT_BIAS_MAX = 3;
  localparam int GATE_BIT = 9;
  localparam logic [NUM_ALM-1:0] TRAP_RST = 10'h000;

  // Alarms ignored for this many bias updates after output enable (window is 8 to 10)
  localparam logic [3:0] STARTUP_IGNORE = 4'h9;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  // Conversion channels, Gray coded from CH_TEMP through CH_MON_THREE
  typedef enum logic [2:0] {
    CH_TEMP = 3'b000,
    CH_VCC = 3'b001,
    CH_MON_ONE = 3'b011,
    CH_MON_TWO = 3'b010,
    CH_MON_THREE = 3'b110
  } lfm_chan_t;

  // Thresholds of one channel
  typedef struct packed {
    logic [15:0] hiAlarm;
    logic [15:0] loAlarm;
    logic [15:0] hiWarn;
    logic [15:0] loWarn;
  } lfm_thresh_t;

  // Masks and controls from lower memory
  typedef struct packed {
    logic [NUM_ALM-1:0] faultMask;
    logic [NUM_ALM-2:0] gateMask;
    logic faultLatchEn;
    logic faultResetPulse;
    logic softTxDisable;
  } lfm_ctrl_t;

  // Flags of one comparison set
  typedef struct packed {
    logic hiAlarm;
    logic loAlarm;
    logic hiWarn;
    logic loWarn;
  } lfm_flags_t;

endpackage : lfm_pkg

/* File: lfm_gate_switch.sv */
// Shutdown switch model: gate pin with pull resistor and series laser switch
`timescale 1ns/10ps
`default_nettype none

module lfm_gate_switch (
  // Gate pin from the device
  input wire logic gateOut,
  input wire logic gateOe,
  // Board strapping
  input wire logic shutdownLevel,
  // Resolved pin and laser current state
  output logic pinLevel,
  output logic laserOn
);
  // ----------------------------------------------------------------
  // Pin resolution
  // ----------------------------------------------------------------
  // Pull resistor holds the pin at the shutdown level while undriven
  assign pinLevel = gateOe ? gateOut : shutdownLevel;
  // Switch conducts only away from the shutdown level
  assign laserOn = (pinLevel !== shutdownLevel);
endmodule : lfm_gate_switch

`default_nettype wire

/* File: laser_fault_alarm_manager_test.sv */
// Self-checking testbench for the laser fault and alarm manager
`timescale 1ns/10ps
`default_nettype none

`define CHK(a, b) begin checked++; if ((a) !== (b)) begin nFail++; \
  $display("CHECK FAILED t=%0t got %h expected %h", $time, (a), (b)); end end

module laser_fault_alarm_manager_test;
  localparam logic [7:0] PART = 8'h3c; // Arbitrary value
  localparam logic [7:0] REV = 8'h02;  // Arbitrary value
  logic clock = 0, reset = 1, belowPoa = 0, txDisable = 0, convDone = 0, biasUpdate = 0;
  logic trapWrite = 0, regWrite = 0, regRead = 0, pol = 0, shortRr = 0;
  logic [15:0] convRaw = '0;
  logic [3:0] quickTrip = '0;
  logic [9:0] trapWrData = '0;
  logic [7:0] regAddr = '0, regWrData = '0, rd;
  lfm_pkg::lfm_thresh_t thr [lfm_pkg::NUM_CHAN];
  lfm_pkg::lfm_ctrl_t ctrl = '0;
  logic txFault, gateOut, gateOe, biasEnable, modEnable, pinLevel, laserOn;
  lfm_pkg::lfm_chan_t convChan;
  logic [15:0] meas [lfm_pkg::NUM_CHAN];
  lfm_pkg::lfm_flags_t flags [lfm_pkg::NUM_CHAN];
  logic [9:0] alarmTrap;
  logic [7:0] regRdData;
  int checked = 0, nFail = 0;

  // ----------------------------------------------------------------
  // Device, switch model and clock
  // ----------------------------------------------------------------
  lfm_fault_manager #(.PART_ID(PART), .REV_ID(REV)) i_dut (
    .clock(clock), .reset(reset), .belowPoa(belowPoa), .txDisable(txDisable),
    .txFault(txFault), .gateOut(gateOut), .gateOe(gateOe), .biasEnable(biasEnable),
    .modEnable(modEnable), .convDone(convDone), .convRaw(convRaw), .convChan(convChan),
    .measResult(meas), .chanFlags(flags), .quickTrip(quickTrip), .biasUpdate(biasUpdate),
    .thresh(thr), .ctrl(ctrl), .trapWrite(trapWrite), .trapWrData(trapWrData),
    .alarmTrap(alarmTrap), .regWrite(regWrite), .regRead(regRead), .regAddr(regAddr),
    .regWrData(regWrData), .regRdData(regRdData)
  );
  lfm_gate_switch i_switch (
    .gateOut(gateOut), .gateOe(gateOe), .shutdownLevel(pol), .pinLevel(pinLevel),
    .laserOn(laserOn)
  );
  // Free-running clock
  always #2 clock = ~clock;

  // ----------------------------------------------------------------
  // Access tasks
  // ----------------------------------------------------------------
  task step(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask : step

  task regWr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    regWrite <= 1'b1;
    regAddr <= a;
    regWrData <= d;
    @(posedge clock);
    regWrite <= 1'b0;
  endtask : regWr

  task regRd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clock);
    regRead <= 1'b1;
    regAddr <= a;
    @(posedge clock);
    regRead <= 1'b0;
    #1;
    d = regRdData;
  endtask : regRd

  task setQt(input logic [3:0] v);
    @(posedge clock);
    quickTrip <= v;
    step(1);
  endtask : setQt

  function automatic lfm_pkg::lfm_chan_t nextCh(input lfm_pkg::lfm_chan_t c);
    case (c)
      lfm_pkg::CH_TEMP: return lfm_pkg::CH_VCC;
      lfm_pkg::CH_VCC: return lfm_pkg::CH_MON_ONE;
      lfm_pkg::CH_MON_ONE: return lfm_pkg::CH_MON_TWO;
      lfm_pkg::CH_MON_TWO: return lfm_pkg::CH_MON_THREE;
      default: return lfm_pkg::CH_TEMP;
    endcase
  endfunction : nextCh

  // One conversion; the channel must step along the expected path
  task pulse(input logic [15:0] raw);
    lfm_pkg::lfm_chan_t e;
    e = nextCh(convChan);
    if (shortRr) begin
      e = (convChan === lfm_pkg::CH_TEMP) ? lfm_pkg::CH_VCC : lfm_pkg::CH_TEMP;
    end
    @(posedge clock);
    convDone <= 1'b1;
    convRaw <= raw;
    @(posedge clock);
    convDone <= 1'b0;
    #1;
    `CHK(convChan, e)
  endtask : pulse

  task conv(input lfm_pkg::lfm_chan_t ch, input logic [15:0] raw);
    int k;
    k = 0;
    while (convChan !== ch && k < 8) begin
      pulse(16'h0800);
      k++;
    end
    pulse(raw);
  endtask : conv

  // Clear supply-low, wait for outputs, then run out the start-up window
  task arm(input logic chkIgnore);
    int k;
    conv(lfm_pkg::CH_VCC, 16'h0800);
    k = 0;
    while (biasEnable !== 1'b1 && k < 50) begin
      step(1);
      k++;
    end
    `CHK(biasEnable, 1'b1)
    if (chkIgnore) begin
      setQt(4'h1);
      `CHK(txFault, 1'b0)
      setQt(4'h0);
    end
    repeat (10) begin
      @(posedge clock);
      biasUpdate <= 1'b1;
      @(posedge clock);
      biasUpdate <= 1'b0;
    end
    step(1);
  endtask : arm

  task give_verdict;
    $display("checks %0d failures %0d", checked, nFail);
    if (nFail == 0 && checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : give_verdict

  // ----------------------------------------------------------------
  // Test sequence
  // ----------------------------------------------------------------
  initial begin
    foreach (thr[i]) thr[i] = '{16'h1000, 16'h0100, 16'h0c00, 16'h0200};
    repeat (6) @(posedge clock);
    reset <= 1'b0;
    step(1);
    `CHK(convChan, lfm_pkg::CH_TEMP)
    `CHK(alarmTrap, lfm_pkg::TRAP_RST)
    regWr(lfm_pkg::ADDR_PART_ID, 8'hff);
    regRd(lfm_pkg::ADDR_PART_ID, rd);
    `CHK(rd, PART)
    regRd(lfm_pkg::ADDR_REV_ID, rd);
    `CHK(rd, REV)
    regRd(8'h20, rd);
    `CHK(rd, lfm_pkg::UNMAPPED_READ)
    regRd(lfm_pkg::ADDR_POLARITY, rd);
    `CHK(rd, lfm_pkg::POLARITY_RST)
    regWr(lfm_pkg::ADDR_POLARITY, 8'h01);
    pol <= 1'b1;
    regWr(lfm_pkg::ADDR_SHIFT_A, 8'h73);
    regWr(lfm_pkg::ADDR_SHIFT_B, 8'h07);
    regRd(lfm_pkg::ADDR_SHIFT_B, rd);
    `CHK(rd, 8'h07)
    arm(1'b0);
    // Signed and unsigned compares, strict bounds, shifted monitors
    conv(lfm_pkg::CH_TEMP, 16'h8000);
    `CHK(flags[0].loAlarm, 1'b1)
    conv(lfm_pkg::CH_VCC, 16'hfff8);
    `CHK(flags[1].hiAlarm, 1'b1)
    conv(lfm_pkg::CH_TEMP, 16'h1000);
    `CHK(flags[0].hiAlarm, 1'b0)
    conv(lfm_pkg::CH_TEMP, 16'h1001);
    `CHK(flags[0].hiAlarm, 1'b1)
    conv(lfm_pkg::CH_MON_ONE, 16'h0100);
    `CHK(meas[2], 16'h0020)
    `CHK(flags[2].loAlarm, 1'b1)
    conv(lfm_pkg::CH_MON_TWO, 16'hfff8);
    `CHK(meas[3], 16'h01ff)
    `CHK(flags[3], 4'h1)
    conv(lfm_pkg::CH_MON_THREE, 16'h0e00);
    `CHK(meas[4], 16'h001c)
    `CHK(alarmTrap[2], 1'b1)
    // Masked quick-trip still trapped; host clears one bit
    setQt(4'h2);
    `CHK(txFault, 1'b0)
    setQt(4'h0);
    @(posedge clock);
    trapWrite <= 1'b1;
    trapWrData <= 10'h3bf;
    @(posedge clock);
    trapWrite <= 1'b0;
    step(1);
    `CHK(alarmTrap[6], 1'b0)
    `CHK(alarmTrap[2], 1'b1)
    // Fault output: follow, latch, reset, disable
    @(posedge clock);
    ctrl.faultMask <= 10'h020;
    setQt(4'h1);
    `CHK(txFault, 1'b1)
    setQt(4'h0);
    `CHK(txFault, 1'b0)
    @(posedge clock);
    ctrl.faultLatchEn <= 1'b1;
    setQt(4'h1);
    setQt(4'h0);
    step(1);
    `CHK(txFault, 1'b1)
    ctrl.faultResetPulse <= 1'b1;
    @(posedge clock);
    ctrl.faultResetPulse <= 1'b0;
    step(1);
    `CHK(txFault, 1'b0)
    setQt(4'h1);
    txDisable <= 1'b1;
    step(2);
    `CHK(txFault, 1'b0)
    `CHK(biasEnable, 1'b0)
    setQt(4'h0);
    txDisable <= 1'b0;
    ctrl.faultLatchEn <= 1'b0;
    arm(1'b1);
    `CHK(flags[2], 4'h0)
    // Shutdown gate: latch, polarity, release
    `CHK(gateOut, 1'b0)
    `CHK(laserOn, 1'b1)
    ctrl.gateMask <= 9'h020;
    ctrl.faultMask <= 10'h200;
    setQt(4'h1);
    setQt(4'h0);
    step(1);
    `CHK(gateOut, 1'b1)
    `CHK(modEnable, 1'b0)
    `CHK(laserOn, 1'b0)
    ctrl.faultResetPulse <= 1'b1;
    @(posedge clock);
    ctrl.faultResetPulse <= 1'b0;
    step(1);
    `CHK(txFault, 1'b1)
    `CHK(gateOut, 1'b1)
    ctrl.softTxDisable <= 1'b1;
    step(2);
    `CHK(gateOut, 1'b0)
    `CHK(txFault, 1'b0)
    ctrl.softTxDisable <= 1'b0;
    ctrl.gateMask <= 9'h000;
    // Low supply: gate floats to the pulled level
    belowPoa <= 1'b1;
    step(2);
    `CHK(gateOe, 1'b0)
    `CHK(pinLevel, 1'b1)
    `CHK(txFault, 1'b1)
    ctrl.faultMask <= 10'h002;
    belowPoa <= 1'b0;
    shortRr = 1'b1;
    repeat (4) pulse(16'h0010);
    // The clearing supply conversion still steps inside the short cycle
    conv(lfm_pkg::CH_VCC, 16'h0800);
    shortRr = 1'b0;
    pulse(16'h0800);
    pulse(16'h0800);
    `CHK(biasEnable, 1'b1)
    give_verdict();
  end

  // Watchdog against a hung handshake
  initial begin
    #200000;
    nFail++;
    give_verdict();
  end
endmodule : laser_fault_alarm_manager_test

`default_nettype wire
